// file: fbcp_pkg.sv
// Package of constants for the flash bus host controller
package fbcp_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned RESET_LOW_NS = 100;
  localparam int unsigned RESET_LOW_CYC =
    (RESET_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Bus cycle phases, in clock cycles (ordinary asynchronous timing)
  localparam int unsigned SETUP_CYC = 1;
  localparam int unsigned STROBE_CYC = 3;
  localparam int unsigned HOLD_CYC = 1;
  localparam int unsigned BLOCK_SHIFT = 16;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] STATUS_AFTER_RESET = 8'h80;
  typedef enum {ST_RESET, ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} fbcp_state_t;
endpackage

// file: fbcp_host.sv
// Host-side controller driving a parallel flash over its bus pins
`timescale 1ns/1ps
module fbcp_host #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // User request side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_byte_mode,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic reset_req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic flash_busy,
  output logic [ADDR_W-fbcp_pkg::BLOCK_SHIFT-1:0] rsp_block,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] dq_in,
  output logic chip_select0_n,
  output logic chip_select1_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic reset_powerdown_n,
  output logic byte_mode_n,
  input wire logic ready_busy_out
);
  localparam int BLOCK_W = fbcp_pkg::BLOCK_SHIFT;

  fbcp_pkg::fbcp_state_t state_reg;
  logic [7:0] cnt_reg;
  logic wr_reg;

  ////////////////////////////////////////////////////////////////////
  // Bus cycle sequencer; one request at a time, strobes from flops
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= fbcp_pkg::ST_RESET;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
      rsp_block <= '0;
      flash_addr <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      chip_select0_n <= 1'b1;
      chip_select1_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
      reset_powerdown_n <= 1'b0;
      byte_mode_n <= 1'b1;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state_reg)
        // Hold power-down low long enough; flash wakes in read array
        fbcp_pkg::ST_RESET:
        begin
          reset_powerdown_n <= 1'b0;
          if (cnt_reg >= 8'(fbcp_pkg::RESET_LOW_CYC))
          begin
            reset_powerdown_n <= 1'b1;
            req_ready <= 1'b1;
            cnt_reg <= 8'h00;
            state_reg <= fbcp_pkg::ST_IDLE;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        end
        fbcp_pkg::ST_IDLE:
        begin
          if (reset_req)
          begin
            req_ready <= 1'b0;
            cnt_reg <= 8'h00;
            state_reg <= fbcp_pkg::ST_RESET;
          end
          else if (req_valid)
          begin
            // Address and data presented before any strobe
            req_ready <= 1'b0;
            wr_reg <= req_write;
            flash_addr <= req_addr;
            rsp_block <= req_addr[ADDR_W-1:BLOCK_W];
            // Pin is high for sixteen-bit mode, low for byte mode
            byte_mode_n <= req_byte_mode;
            // Command words pass through untouched; the user picks the
            // read mode and issues read-array after an operation
            dq_out <= req_wdata;
            chip_select0_n <= 1'b0;
            chip_select1_n <= 1'b0;
            cnt_reg <= 8'h00;
            state_reg <= fbcp_pkg::ST_SETUP;
          end
        end
        fbcp_pkg::ST_SETUP:
        begin
          if (cnt_reg >= 8'(fbcp_pkg::SETUP_CYC - 1))
          begin
            // Write enable and output enable never overlap
            write_enable_n <= ~wr_reg;
            output_enable_n <= wr_reg;
            dq_oe <= wr_reg;
            cnt_reg <= 8'h00;
            state_reg <= fbcp_pkg::ST_STROBE;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        end
        fbcp_pkg::ST_STROBE:
        begin
          if (cnt_reg >= 8'(fbcp_pkg::STROBE_CYC - 1))
          begin
            // Write enable rises before chip select, so it latches
            write_enable_n <= 1'b1;
            output_enable_n <= 1'b1;
            if (!wr_reg)
            begin
              // Width taken from the pin, not the live request input
              rsp_rdata <= byte_mode_n ? dq_in :
                {{(DATA_W-8){1'b0}}, dq_in[7:0]};
              rsp_valid <= 1'b1;
            end
            cnt_reg <= 8'h00;
            state_reg <= fbcp_pkg::ST_HOLD;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        end
        fbcp_pkg::ST_HOLD:
        begin
          // Data held past the write edge, then deselect
          if (cnt_reg >= 8'(fbcp_pkg::HOLD_CYC - 1))
          begin
            dq_oe <= 1'b0;
            chip_select0_n <= 1'b1;
            chip_select1_n <= 1'b1;
            req_ready <= 1'b1;
            cnt_reg <= 8'h00;
            state_reg <= fbcp_pkg::ST_IDLE;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        end
        default:
          state_reg <= fbcp_pkg::ST_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Busy is the open-drain ready/busy pin seen low; power-down masks it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      flash_busy <= 1'b0;
    else
      flash_busy <= reset_powerdown_n & ~ready_busy_out;
  end

  ////////////////////////////////////////////////////////////////////
  // Checks on the pin protocol
  chk_no_drive_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !output_enable_n |-> !dq_oe && write_enable_n)
    else $error("data driven or write during read");
  chk_read_selects: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !output_enable_n |-> !chip_select0_n && !chip_select1_n
      && reset_powerdown_n)
    else $error("read without full select");
  chk_write_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(write_enable_n) |-> !chip_select0_n)
    else $error("chip select rose before write enable");
  chk_write_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !write_enable_n |-> dq_oe && $stable(dq_out) && $stable(flash_addr))
    else $error("write data not stable");
  chk_reset_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(reset_powerdown_n) |-> !reset_powerdown_n [*2])
    else $error("power-down pulse too short");
  chk_ready_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(reset_powerdown_n) |-> req_ready)
    else $error("not ready after power-down exit");
  // Busy is not reported while the flash sits in power-down
  chk_busy_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !reset_powerdown_n |=> !flash_busy)
    else $error("busy reported during power-down");
  // Deselected flash must never see a read or write strobe
  chk_float_deselect: assert property (@(posedge ref_clk) disable iff (!rst_n)
    chip_select0_n |-> output_enable_n && write_enable_n && !dq_oe)
    else $error("strobe or drive while deselected");
  // Idle controller leaves the bus quiet
  chk_idle_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    req_ready |-> chip_select0_n && chip_select1_n)
    else $error("chip selected while idle");
  // Read data is captured only at the end of an output-enable pulse
  chk_read_sample: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rsp_valid |-> $past(!output_enable_n))
    else $error("read data taken without output enable");
  // A response lasts exactly one cycle
  chk_rsp_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  // Power-down keeps every strobe inactive
  chk_pd_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !reset_powerdown_n |-> write_enable_n && output_enable_n)
    else $error("strobe during power-down");
endmodule

// file: fbcp_flash_model.sv
// Behavioural flash device seen from the host controller's pins
`timescale 1ns/1ps
module fbcp_flash_model (
  // Bus pins
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  output logic [15:0] dq_in,
  input wire logic chip_select0_n,
  input wire logic chip_select1_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic reset_powerdown_n,
  input wire logic byte_mode_n,
  // Status pin, driven high when not busy
  output wire ready_busy_out
);
  logic stat_mode = 1'b0;
  logic busy = 1'b0;
  logic [15:0] last_q = 16'h0;
  logic [15:0] rd;
  logic [7:0] prev_cmd = 8'hff;
  logic lockout = 1'b0; // Programming supply held valid in this bench
  logic [63:0] locked = '0; // Per-block protection bits
  wire sel = !chip_select0_n && !chip_select1_n && reset_powerdown_n;
  wire wr_act = sel && !write_enable_n;
  wire drive = sel && !output_enable_n && write_enable_n;
  ////////////////////////////////////////////////////////////////////////
  // Latch on the first rising strobe; reset low ignores it
  always @(negedge wr_act)
  begin
    if (reset_powerdown_n && dq_oe)
    begin
      // Read-array clears status mode; status and erase commands set it
      if (dq_out[7:0] == 8'hff)
        stat_mode = 1'b0;
      else if (dq_out[7:0] == 8'h70 || dq_out[7:0] == 8'h20 ||
        dq_out[7:0] == 8'hd0)
        stat_mode = 1'b1;
      // Suspend releases the busy pin while the operation is held
      if (dq_out[7:0] == 8'hb0)
        busy = 1'b0;
      // Erase starts only on setup then confirm
      if (prev_cmd == 8'h20 && dq_out[7:0] == 8'hd0 && !lockout &&
        !locked[flash_addr[21:16]])
      begin
        busy = 1'b1; // Runs alone, even deselected
        busy <= #500 1'b0;
      end
      prev_cmd = dq_out[7:0];
    end
  end
  // Power-down entry gives array mode and idle status
  always @(negedge reset_powerdown_n)
  begin
    stat_mode = 1'b0;
    busy = 1'b0;
    prev_cmd = 8'hff;
  end
  ////////////////////////////////////////////////////////////////////////
  // Read data; a floating bus shows the inverse of the last value
  assign rd = stat_mode ? 16'h0080 : flash_addr[15:0] ^ 16'h5a5a;
  always @*
  begin
    if (drive)
      last_q = rd;
  end
  assign dq_in[7:0] = drive ? rd[7:0] : ~last_q[7:0];
  assign dq_in[15:8] = (drive && byte_mode_n) ? rd[15:8] : ~last_q[15:8];
  assign ready_busy_out = busy ? 1'b0 : 1'b1;
endmodule

// file: tb_flash_bus_control_and_protect.sv
// Self-checking bench for the flash bus host controller
`timescale 1ns/1ps
module tb_flash_bus_control_and_protect;
  typedef struct packed {
    logic w; logic b; logic [21:0] a; logic [15:0] d; logic [15:0] e;
  } fbcp_row_t;
  logic ref_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic req_byte_mode = 1'b1, reset_req = 1'b0;
  logic [21:0] req_addr = 22'h0, flash_addr;
  logic [15:0] req_wdata = 16'h0, rsp_rdata, dq_out, dq_in, r;
  logic req_ready, rsp_valid, flash_busy, dq_oe, chip_select0_n;
  logic chip_select1_n, output_enable_n, write_enable_n, reset_powerdown_n;
  logic byte_mode_n;
  wire ready_busy_out;
  logic [5:0] rsp_block;
  int bad_count = 0, n_tests = 0;
  // Ordinary cases: write, x16, address, data, expected read
  fbcp_row_t rows [6] = '{'{1'b0, 1'b1, 22'h1f0000, 16'h0, 16'h5a5a},
    '{1'b1, 1'b1, 22'h0, 16'h0070, 16'h0}, '{1'b0, 1'b1, 22'h010000, 16'h0,
    16'h0080}, '{1'b1, 1'b0, 22'h0, 16'h00ff, 16'h0}, '{1'b0, 1'b0,
    22'h3fffff, 16'h0, 16'h00a5}, '{1'b0, 1'b1, 22'h20ffff, 16'h0, 16'ha5a5}};
  fbcp_host fbcp_host_inst (.ref_clk, .rst_n, .req_valid, .req_write,
    .req_byte_mode, .req_addr, .req_wdata, .reset_req, .req_ready, .rsp_valid,
    .rsp_rdata, .flash_busy, .rsp_block, .flash_addr, .dq_out, .dq_oe, .dq_in,
    .chip_select0_n, .chip_select1_n, .output_enable_n, .write_enable_n,
    .reset_powerdown_n, .byte_mode_n, .ready_busy_out);
  fbcp_flash_model fbcp_flash_model_inst (.flash_addr, .dq_out, .dq_oe,
    .dq_in, .chip_select0_n, .chip_select1_n, .output_enable_n,
    .write_enable_n, .reset_powerdown_n, .byte_mode_n, .ready_busy_out);
  ////////////////////////////////////////////////////////////////////////
  task chk(string n, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // One bus request, driven on falling edges, waits bounded
  task xfer(logic w, logic b, logic [21:0] a, logic [15:0] d);
    int i;
    i = 0;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && i < 100)
    begin
      @(negedge ref_clk);
      i++;
    end
    if (i >= 100)
      bad_count++;
    {req_valid, req_write, req_byte_mode, req_addr, req_wdata} = {1'b1, w, b, a, d};
    @(negedge ref_clk);
    req_valid = 1'b0;
    r = 16'h0;
    while (!w && rsp_valid !== 1'b1 && i < 200)
    begin
      @(negedge ref_clk);
      i++;
    end
    if (i >= 200)
      bad_count++;
    r = rsp_rdata;
  endtask
  task complete_run;
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial forever #25 ref_clk = ~ref_clk;
  // Hang guard, far beyond the hundred or so cycles the tests need
  initial
  begin
    #200000;
    bad_count++;
    complete_run;
  end
  initial
  begin
    repeat (5) @(negedge ref_clk);
    chk("req_ready", 16'h0, {15'h0, req_ready});
    chk("powerdown_n", 16'h0, {15'h0, reset_powerdown_n});
    rst_n = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      xfer(rows[k].w, rows[k].b, rows[k].a, rows[k].d);
      if (!rows[k].w)
        chk("rdata", rows[k].e, r);
      chk("block", {10'h0, rows[k].a[21:16]}, {10'h0, rsp_block});
    end
    // Status mode, then a long operation keeps the flash busy
    xfer(1'b1, 1'b1, 22'h0, 16'h0070);
    xfer(1'b1, 1'b1, 22'h050000, 16'h0020);
    xfer(1'b1, 1'b1, 22'h050000, 16'h00d0);
    repeat (6) @(negedge ref_clk);
    chk("busy", 16'h1, {15'h0, flash_busy});
    xfer(1'b0, 1'b1, 22'h0, 16'h0);
    chk("status", 16'h0080, r);
    repeat (12) @(negedge ref_clk);
    chk("idle", 16'h0, {15'h0, flash_busy});
    xfer(1'b1, 1'b1, 22'h0, 16'h00ff);
    xfer(1'b0, 1'b1, 22'h000002, 16'h0);
    chk("readback", 16'h5a58, r);
    // Power-down request pulse falls in the hold phase and is ignored; array reads stay
    reset_req = 1'b1;
    @(negedge ref_clk);
    reset_req = 1'b0;
    xfer(1'b0, 1'b1, 22'h000001, 16'h0);
    chk("array", 16'h5a5b, r);
    complete_run;
  end
endmodule
